// ===== rtl/asr_receiver.v
// Asynchronous serial receiver with Avalon-MM register slave
//
// The Avalon-MM register port is this design's own decision.
`timescale 1ns/1ps
`default_nettype none
`include "asr_defines.vh"

module asr_receiver (
  input  wire        sys_clk,
  input  wire        resetn,
  input  wire [9:0]  avs_address,
  input  wire        avs_read,
  input  wire        avs_write,
  input  wire [31:0] avs_writedata,
  input  wire [3:0]  avs_byteenable,
  output reg  [31:0] avs_readdata,
  output wire        avs_waitrequest,
  input  wire        serial_receive_pin,
  output wire        irq
);

  // Receive state codes
  localparam [1:0] ST_IDLE  = 2'h0;
  localparam [1:0] ST_START = 2'h1;
  localparam [1:0] ST_DATA  = 2'h2;
  localparam [1:0] ST_STOP  = 2'h3;

  // Software registers
  reg  [7:0]  interrupt_control_reg;
  reg  [7:0]  pflags_sw_reg;
  reg  [7:0]  peripheral_irq_enables_reg;
  reg  [7:0]  rxsc_ctl_reg;
  reg  [7:0]  transmit_status_control_reg;
  reg  [7:0]  baud_divisor_reg;
  reg  [`ASR_EVT_W-1:0] evt_mask_reg;
  reg  [`ASR_EVT_W-1:0] evt_status_reg;
  reg         overrun_error_reg;

  // Bus handshake
  reg         ack_reg;
  wire [7:0]  reg_index;
  wire        bus_req;
  wire        rd_done;
  wire        wr_done;
  wire        wr_lane0;
  wire        rd_rxbuf;
  wire        rd_evt;

  // Baud and oversampling
  reg  [9:0]  baud_cnt_reg;
  wire [9:0]  baud_limit;
  wire        ovs_tick;

  // Pin synchroniser
  reg         rx_meta_reg;
  reg         rx_sync_reg;
  reg         rx_prev_reg;

  // Receiver state
  reg  [1:0]  state_reg;
  reg  [3:0]  ovs_cnt_reg;
  reg  [3:0]  bit_cnt_reg;
  reg  [8:0]  receive_shift_register;
  wire        rx_enabled;
  wire [3:0]  bits_needed;

  // Two-deep buffer
  reg  [9:0]  fifo_mem [0:1];
  reg         wr_ptr_reg;
  reg         rd_ptr_reg;
  reg  [1:0]  fifo_cnt_reg;
  wire        fifo_full;
  wire        fifo_empty;
  wire        push;
  wire        pop;
  wire [9:0]  fifo_head;

  // Stop-bit outcome
  wire        stop_sample;
  wire        stop_bit_bad;
  wire        addr_reject;
  wire        overrun_hit;

  // Read mux
  reg  [7:0]  rd_mux;
  wire [`ASR_EVT_W-1:0] evt_set;
  wire [`ASR_EVT_W-1:0] evt_clr;
  wire        irq_rx;
  wire        irq_evt;

  // Decoded control fields
  wire        continuous_receive_enable;
  wire        serial_port_enable;
  wire        nine_bit_receive_select;
  wire        address_detect_enable;
  wire        baud_high_speed_select;
  wire        receive_flag;
  wire        receive_irq_enable;

  assign continuous_receive_enable = rxsc_ctl_reg[`ASR_BIT_CONTRX];
  assign serial_port_enable        = rxsc_ctl_reg[`ASR_BIT_PORTEN];
  assign nine_bit_receive_select   = rxsc_ctl_reg[`ASR_BIT_NINESEL];
  assign address_detect_enable     = rxsc_ctl_reg[`ASR_BIT_ADDRDET];
  assign baud_high_speed_select    = transmit_status_control_reg[`ASR_BIT_HISPEED];
  assign receive_irq_enable        = peripheral_irq_enables_reg[`ASR_BIT_RXIE];

  // One wait state per access: request seen, answered next cycle
  assign reg_index       = avs_address[9:2];
  assign bus_req         = avs_read | avs_write;
  assign avs_waitrequest = bus_req & ~ack_reg;
  assign rd_done         = avs_read & ack_reg;
  assign wr_done         = avs_write & ack_reg;
  assign wr_lane0        = wr_done & avs_byteenable[0];

  // Reads with side effects: buffer pop and event clear
  assign rd_rxbuf        = rd_done & (reg_index == `ASR_IDX_RXBUF);
  assign rd_evt          = rd_done & (reg_index == `ASR_IDX_EVT);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= bus_req & ~ack_reg;
    end
  end

  // Flag follows buffer occupancy, so reads emptying it clear it
  assign receive_flag = ~fifo_empty;

  // Read data assembly; unmapped indices read as zero
  always @* begin
    case (reg_index)
      `ASR_IDX_INTCTL:  rd_mux = interrupt_control_reg;
      `ASR_IDX_PFLAGS: begin
        rd_mux = pflags_sw_reg;
        rd_mux[`ASR_BIT_RXFLAG] = receive_flag;
      end
      `ASR_IDX_RXSC: begin
        rd_mux = rxsc_ctl_reg;
        rd_mux[`ASR_BIT_FRAMERR] = fifo_head[9];
        rd_mux[`ASR_BIT_OVERRUN] = overrun_error_reg;
        rd_mux[`ASR_BIT_NINTH]   = fifo_head[8];
      end
      `ASR_IDX_RXBUF:   rd_mux = fifo_head[7:0];
      `ASR_IDX_PENABLE: rd_mux = peripheral_irq_enables_reg;
      `ASR_IDX_TXSC:    rd_mux = transmit_status_control_reg;
      `ASR_IDX_BAUD:    rd_mux = baud_divisor_reg;
      `ASR_IDX_EVT:     rd_mux = {5'h00, evt_status_reg};
      `ASR_IDX_EVTMASK: rd_mux = {5'h00, evt_mask_reg};
      default:          rd_mux = 8'h00;
    endcase
  end

  // Data is captured in the wait cycle and stands at the answer edge
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      avs_readdata <= 32'h00000000;
    end else if (avs_read & ~ack_reg) begin
      avs_readdata <= {24'h000000, rd_mux};
    end
  end

  // Writable registers; status-only bits are masked off
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      interrupt_control_reg       <= `ASR_RST_INTCTL;
      pflags_sw_reg               <= `ASR_RST_PFLAGS;
      peripheral_irq_enables_reg  <= `ASR_RST_PENABLE;
      rxsc_ctl_reg                <= `ASR_RST_RXSC;
      transmit_status_control_reg <= `ASR_RST_TXSC;
      baud_divisor_reg            <= `ASR_RST_BAUD;
      evt_mask_reg                <= 3'h0;
    end else if (wr_lane0) begin
      case (reg_index)
        `ASR_IDX_INTCTL:  interrupt_control_reg <= avs_writedata[7:0];
        `ASR_IDX_PFLAGS:  pflags_sw_reg <= avs_writedata[7:0] & `ASR_PFLAGS_WMASK;
        `ASR_IDX_PENABLE: peripheral_irq_enables_reg <= avs_writedata[7:0];
        `ASR_IDX_RXSC:    rxsc_ctl_reg <= avs_writedata[7:0] & `ASR_RXSC_WMASK;
        `ASR_IDX_TXSC: begin
          // Shift-register-empty bit reads as one: no transmitter here
          transmit_status_control_reg <=
            (avs_writedata[7:0] & `ASR_TXSC_WMASK) | `ASR_RST_TXSC;
        end
        `ASR_IDX_BAUD:    baud_divisor_reg <= avs_writedata[7:0];
        `ASR_IDX_EVTMASK: evt_mask_reg <= avs_writedata[2:0];
        default: begin
        end
      endcase
    end
  end

  // Oversampling tick: x16 of baud; low range adds a divide by four
  assign baud_limit = baud_high_speed_select ?
                      {2'h0, baud_divisor_reg} :
                      {baud_divisor_reg, `ASR_LOW_PRESCALE};
  assign ovs_tick   = (baud_cnt_reg == baud_limit);

  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      baud_cnt_reg <= 10'h000;
    end else if (ovs_tick | ~rx_enabled) begin
      baud_cnt_reg <= 10'h000;
    end else begin
      baud_cnt_reg <= baud_cnt_reg + 10'h001;
    end
  end

  // Pin crosses in from outside; only the second stage is read
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_meta_reg <= 1'b1;
      rx_sync_reg <= 1'b1;
    end else begin
      rx_meta_reg <= serial_receive_pin;
      rx_sync_reg <= rx_meta_reg;
    end
  end

  // Line level at the last tick; a start needs high then low, so a line
  // held low at enable or after a low stop bit starts no character
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      rx_prev_reg <= 1'b1;
    end else if (!rx_enabled) begin
      rx_prev_reg <= 1'b0;
    end else if (ovs_tick) begin
      rx_prev_reg <= rx_sync_reg;
    end
  end

  // Clearing either enable holds the receive logic in reset
  assign rx_enabled  = serial_port_enable & continuous_receive_enable;
  assign bits_needed = nine_bit_receive_select ? `ASR_BITS_NINE : `ASR_BITS_EIGHT;

  // Receive sequencer, advanced only on oversampling ticks
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      state_reg              <= ST_IDLE;
      ovs_cnt_reg            <= 4'h0;
      bit_cnt_reg            <= 4'h0;
      receive_shift_register <= 9'h000;
    end else if (!rx_enabled) begin
      state_reg   <= ST_IDLE;
      ovs_cnt_reg <= 4'h0;
      bit_cnt_reg <= 4'h0;
    end else if (ovs_tick) begin
      case (state_reg)
        ST_IDLE: begin
          ovs_cnt_reg <= 4'h0;
          // Falling edge between two ticks marks a start
          if (rx_prev_reg & ~rx_sync_reg) begin
            state_reg <= ST_START;
          end
        end
        ST_START: begin
          // A glitch shorter than half a bit is not a start
          if (ovs_cnt_reg == `ASR_OVS_MID) begin
            ovs_cnt_reg <= 4'h0;
            bit_cnt_reg <= 4'h0;
            state_reg   <= rx_sync_reg ? ST_IDLE : ST_DATA;
          end else begin
            ovs_cnt_reg <= ovs_cnt_reg + 4'h1;
          end
        end
        ST_DATA: begin
          ovs_cnt_reg <= ovs_cnt_reg + 4'h1;
          if (ovs_cnt_reg == `ASR_OVS_LAST) begin
            // One shift per bit period at the bit centre, LSB first
            receive_shift_register <= nine_bit_receive_select ?
              {rx_sync_reg, receive_shift_register[8:1]} :
              {1'b0, rx_sync_reg, receive_shift_register[7:1]};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
            if (bit_cnt_reg == bits_needed - 4'h1) begin
              state_reg <= ST_STOP;
            end
          end
        end
        ST_STOP: begin
          ovs_cnt_reg <= ovs_cnt_reg + 4'h1;
          if (ovs_cnt_reg == `ASR_OVS_LAST) begin
            state_reg <= ST_IDLE;
          end
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // Stop bit sampled at its centre
  assign stop_sample  = rx_enabled & ovs_tick & (state_reg == ST_STOP) &
                        (ovs_cnt_reg == `ASR_OVS_LAST);
  assign stop_bit_bad = ~rx_sync_reg;
  // Address detect in nine-bit mode drops words whose ninth bit is clear
  assign addr_reject  = address_detect_enable & nine_bit_receive_select &
                        ~receive_shift_register[8];
  assign overrun_hit  = stop_sample & ~addr_reject & fifo_full &
                        ~overrun_error_reg;
  assign push = stop_sample & ~addr_reject & ~fifo_full &
                ~overrun_error_reg;
  assign pop  = rd_rxbuf & ~fifo_empty;

  // Overrun stays until software clears the continuous receive enable
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      overrun_error_reg <= 1'b0;
    end else if (!continuous_receive_enable) begin
      overrun_error_reg <= 1'b0;
    end else if (overrun_hit) begin
      overrun_error_reg <= 1'b1;
    end
  end

  // Two-entry buffer; each entry carries framing error and ninth bit
  assign fifo_full  = (fifo_cnt_reg == 2'h2);
  assign fifo_empty = (fifo_cnt_reg == 2'h0);
  assign fifo_head  = fifo_mem[rd_ptr_reg];

  // Storage has no reset; the count says which entries are valid
  always @(posedge sys_clk) begin
    if (push) begin
      fifo_mem[wr_ptr_reg] <= {stop_bit_bad, receive_shift_register};
    end
  end

  // Pointers and occupancy count
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      wr_ptr_reg   <= 1'b0;
      rd_ptr_reg   <= 1'b0;
      fifo_cnt_reg <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (pop) begin
        rd_ptr_reg <= ~rd_ptr_reg;
      end
      case ({push, pop})
        2'b10:   fifo_cnt_reg <= fifo_cnt_reg + 2'h1;
        2'b01:   fifo_cnt_reg <= fifo_cnt_reg - 2'h1;
        default: fifo_cnt_reg <= fifo_cnt_reg;
      endcase
    end
  end

  // Sticky events; a read clears only the bits it returned, so
  // an event landing between capture and answer is kept
  assign evt_set[`ASR_EVT_WORD] = push;
  assign evt_set[`ASR_EVT_OVR]  = overrun_hit;
  assign evt_set[`ASR_EVT_FRM]  = stop_sample & stop_bit_bad;
  assign evt_clr = rd_evt ?
                   avs_readdata[2:0] : 3'h0;

  genvar gi;
  generate
    for (gi = 0; gi < `ASR_EVT_W; gi = gi + 1) begin : g_evt
      always @(posedge sys_clk or negedge resetn) begin
        if (!resetn) begin
          evt_status_reg[gi] <= 1'b0;
        end else if (evt_set[gi]) begin
          evt_status_reg[gi] <= 1'b1;
        end else if (evt_clr[gi]) begin
          evt_status_reg[gi] <= 1'b0;
        end
      end
    end
  endgenerate

  // One level line: receive flag with its enable, or unmasked events
  assign irq_rx  = receive_flag & receive_irq_enable;
  assign irq_evt = |(evt_status_reg & evt_mask_reg);
  assign irq     = irq_rx | irq_evt;

endmodule
`default_nettype wire

// ===== rtl/asr_defines.vh
// Constants for the asynchronous serial receiver block
`ifndef ASR_DEFINES_VH
`define ASR_DEFINES_VH

// Register indices; byte address is four times the index
`define ASR_IDX_INTCTL   8'h0b
`define ASR_IDX_PFLAGS   8'h0c
`define ASR_IDX_RXSC     8'h18
`define ASR_IDX_RXBUF    8'h1a
`define ASR_IDX_PENABLE  8'h8c
`define ASR_IDX_TXSC     8'h98
`define ASR_IDX_BAUD     8'h99
`define ASR_IDX_EVT      8'ha0
`define ASR_IDX_EVTMASK  8'ha1

// Reset values
`define ASR_RST_INTCTL   8'h00
`define ASR_RST_PFLAGS   8'h00
`define ASR_RST_RXSC     8'h00
`define ASR_RST_PENABLE  8'h00
`define ASR_RST_TXSC     8'h02
`define ASR_RST_BAUD     8'h00

// Field positions
`define ASR_BIT_RXFLAG   5
`define ASR_BIT_RXIE     5
`define ASR_BIT_PORTEN   7
`define ASR_BIT_NINESEL  6
`define ASR_BIT_CONTRX   4
`define ASR_BIT_ADDRDET  3
`define ASR_BIT_FRAMERR  2
`define ASR_BIT_OVERRUN  1
`define ASR_BIT_NINTH    0
`define ASR_BIT_HISPEED  2
`define ASR_TXSC_WMASK   8'hf5
`define ASR_PFLAGS_WMASK 8'hdf
`define ASR_RXSC_WMASK   8'hf8

// Event bits
`define ASR_EVT_WORD     0
`define ASR_EVT_OVR      1
`define ASR_EVT_FRM      2
`define ASR_EVT_W        3

// Oversampling figures
`define ASR_OVS_LAST     4'hf
`define ASR_OVS_MID      4'h7
`define ASR_LOW_PRESCALE 2'h3
`define ASR_BITS_NINE    4'h9
`define ASR_BITS_EIGHT   4'h8

`endif

// ===== verification/asr_tx_model.sv
// Remote asynchronous transmitter model that drives the receive line
`timescale 1ns/1ps
`default_nettype none
module asr_tx_model #(
  parameter int BIT_CLKS = 16
) (
  input  wire logic sys_clk,
  output var logic  line
);
  // Line rests high as a pulled-up idle line does
  initial line = 1'b1;

  // Bit length in clocks; the bench may change it between frames
  int bit_clks = BIT_CLKS;

  // Start low, data LSB first, stop as asked, then one idle bit so a
  // low stop still leaves a falling edge for the next start
  task automatic send(input logic [8:0] data, input int nbits, input logic stop);
    int i;
    for (i = 0; i < nbits + 3; i++) begin
      @(posedge sys_clk);
      line <= (i == 0) ? 1'b0 : (i <= nbits) ? data[i-1] : (i == nbits + 1) ? stop : 1'b1;
      repeat (bit_clks - 1) @(posedge sys_clk);
    end
  endtask
endmodule
`default_nettype wire

// ===== verification/asr_receiver_monitor.sv
// Checker of the register handshake and interrupt output of the receiver
`timescale 1ns/1ps
`default_nettype none
module asr_receiver_monitor (
  input wire logic        sys_clk,
  input wire logic        resetn,
  input wire logic [9:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        serial_receive_pin,
  input wire logic        irq
);
  logic [7:0] idx;
  logic       mapped;
  logic       pie_reg;
  logic       msk_reg;
  logic       wr_ok;

  // Decode of the word index and of the mapped places
  assign idx    = avs_address[9:2];
  assign wr_ok  = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign mapped = idx inside {8'h0b, 8'h0c, 8'h18, 8'h1a, 8'h8c, 8'h98, 8'h99, 8'ha0, 8'ha1};

  // Shadow of the two interrupt sources' enables, from accepted writes
  always @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      pie_reg <= 1'b0;
      msk_reg <= 1'b0;
    end else if (wr_ok) begin
      if (idx == 8'h8c) pie_reg <= avs_writedata[5];
      if (idx == 8'ha1) msk_reg <= |avs_writedata[2:0];
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!resetn);

  a_wait_first: assert property ($rose(avs_read || avs_write) |-> avs_waitrequest)
    else $error("waitrequest low in first request cycle");
  a_one_wait: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
    else $error("more than one wait state");
  a_idle_nowait: assert property (!(avs_read || avs_write) |-> !avs_waitrequest)
    else $error("waitrequest without request");
  a_data_upper: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:8] == 24'h0)
    else $error("read data upper bits not zero");
  a_data_hold: assert property (!$stable(avs_readdata) |-> $past(avs_read && avs_waitrequest))
    else $error("read data changed outside a read");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && !mapped |-> avs_readdata == 32'h0)
    else $error("unmapped read not zero");
  a_irq_enable: assert property (irq |-> pie_reg || msk_reg)
    else $error("interrupt without enable");
  a_irq_fall: assert property ($fell(irq) |-> $past(!avs_waitrequest && (avs_read || avs_write)))
    else $error("interrupt dropped without access");

  c_read: cover property (avs_read && !avs_waitrequest);
  c_irq_up: cover property ($rose(irq));
  c_irq_down: cover property ($fell(irq));
endmodule

bind asr_receiver asr_receiver_monitor i_mon (
  .sys_clk            (sys_clk),
  .resetn             (resetn),
  .avs_address        (avs_address),
  .avs_read           (avs_read),
  .avs_write          (avs_write),
  .avs_writedata      (avs_writedata),
  .avs_byteenable     (avs_byteenable),
  .avs_readdata       (avs_readdata),
  .avs_waitrequest    (avs_waitrequest),
  .serial_receive_pin (serial_receive_pin),
  .irq                (irq)
);
`default_nettype wire

// ===== verification/asr_receiver_tb.sv
// Self-checking bench for the asynchronous serial receiver
`timescale 1ns/1ps
`default_nettype none
module asr_receiver_tb;
  logic        sys_clk = 1'b0;
  logic        resetn = 1'b0;
  logic [9:0]  avs_address = 10'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [3:0]  avs_byteenable = 4'h1;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_line;
  logic        irq;
  int          miscompares = 0;
  int          n_checks = 0;
  int          i;
  logic [7:0]  idxs [9] = '{8'h0b, 8'h0c, 8'h18, 8'h8c, 8'h98, 8'h99, 8'ha0, 8'ha1, 8'h05};
  logic [7:0]  exps [9] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 8'h00, 8'h00};

  // 10 MHz system clock
  always #50 sys_clk = ~sys_clk;

  asr_receiver i_dut (
    .sys_clk            (sys_clk),
    .resetn             (resetn),
    .avs_address        (avs_address),
    .avs_read           (avs_read),
    .avs_write          (avs_write),
    .avs_writedata      (avs_writedata),
    .avs_byteenable     (avs_byteenable),
    .avs_readdata       (avs_readdata),
    .avs_waitrequest    (avs_waitrequest),
    .serial_receive_pin (rx_line),
    .irq                (irq)
  );

  // Divisor 0 with high speed gives one tick a clock, 16 clocks a bit
  asr_tx_model #(.BIT_CLKS(16)) i_tx (
    .sys_clk (sys_clk),
    .line    (rx_line)
  );

  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // One bus cycle; the request stands until waitrequest is sampled low
  // at a rising edge, read data is taken at that edge, then released
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] q);
    int n;
    @(posedge sys_clk);
    avs_address <= {idx, 2'b00};
    avs_writedata <= {24'h0, wd};
    avs_read <= !wr;
    avs_write <= wr;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      miscompares++;
      report_and_stop;
    end
    q = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    logic [31:0] q;
    bus(1'b1, idx, d, q);
  endtask

  task automatic rd(input logic [7:0] idx, input logic [7:0] m, input logic [7:0] e);
    logic [31:0] q;
    bus(1'b0, idx, 8'h00, q);
    chk($sformatf("reg %h", idx), {24'h0, e & m}, q & {24'h0, m});
  endtask

  // Bounded wait for the interrupt line
  task automatic wait_irq;
    int n;
    n = 0;
    while (irq !== 1'b1 && n < 400) begin
      @(negedge sys_clk);
      n++;
    end
    chk("irq", 32'h1, {31'h0, irq});
  endtask

  initial begin
    repeat (5) @(posedge sys_clk);
    resetn <= 1'b1;
    wr(8'h05, 8'hff);
    for (i = 0; i < 9; i++) rd(idxs[i], 8'hff, exps[i]);
    wr(8'h98, 8'hff);
    rd(8'h98, 8'hff, 8'hf7);
    avs_byteenable <= 4'h0;
    wr(8'h99, 8'h5a);
    avs_byteenable <= 4'h1;
    rd(8'h99, 8'hff, 8'h00);
    wr(8'h0c, 8'h21);
    rd(8'h0c, 8'hff, 8'h01);
    $display("test registers done");
    wr(8'h0c, 8'h00);
    wr(8'h99, 8'h00);
    wr(8'h98, 8'h04);
    wr(8'h8c, 8'h20);
    wr(8'h18, 8'h90);
    i_tx.send(9'h0a5, 8, 1'b1);
    wait_irq;
    rd(8'h0c, 8'hff, 8'h20);
    rd(8'h1a, 8'hff, 8'ha5);
    rd(8'h0c, 8'hff, 8'h00);
    chk("irq", 32'h0, {31'h0, irq});
    $display("test single word done");
    i_tx.send(9'h011, 8, 1'b1);
    i_tx.send(9'h022, 8, 1'b0);
    i_tx.send(9'h033, 8, 1'b1);
    repeat (40) @(negedge sys_clk);
    rd(8'h18, 8'hff, 8'h92);
    rd(8'h1a, 8'hff, 8'h11);
    rd(8'h18, 8'hff, 8'h96);
    rd(8'h1a, 8'hff, 8'h22);
    i_tx.send(9'h044, 8, 1'b1);
    repeat (40) @(negedge sys_clk);
    rd(8'h0c, 8'hff, 8'h00);
    wr(8'h18, 8'h80);
    i_tx.send(9'h066, 8, 1'b1);
    repeat (40) @(negedge sys_clk);
    rd(8'h0c, 8'hff, 8'h00);
    wr(8'h18, 8'h90);
    rd(8'h18, 8'h02, 8'h00);
    i_tx.send(9'h055, 8, 1'b1);
    wait_irq;
    rd(8'h1a, 8'hff, 8'h55);
    rd(8'ha0, 8'hff, 8'h07);
    rd(8'ha0, 8'hff, 8'h00);
    $display("test overrun done");
    wr(8'h8c, 8'h00);
    wr(8'ha1, 8'h01);
    wr(8'h18, 8'hd0);
    i_tx.send(9'h13c, 9, 1'b1);
    wait_irq;
    rd(8'ha0, 8'hff, 8'h01);
    @(negedge sys_clk);
    chk("irq", 32'h0, {31'h0, irq});
    rd(8'h18, 8'hff, 8'hd1);
    rd(8'h1a, 8'hff, 8'h3c);
    $display("test nine bit done");
    wr(8'h18, 8'hd8);
    i_tx.send(9'h0c3, 9, 1'b1);
    rd(8'h0c, 8'hff, 8'h00);
    i_tx.send(9'h1c3, 9, 1'b1);
    rd(8'h0c, 8'hff, 8'h20);
    rd(8'h18, 8'hff, 8'hd9);
    rd(8'h1a, 8'hff, 8'hc3);
    $display("test address detect done");
    wr(8'h18, 8'h90);
    wr(8'h98, 8'h00);
    i_tx.bit_clks = 64;
    i_tx.send(9'h05a, 8, 1'b1);
    rd(8'h0c, 8'hff, 8'h20);
    rd(8'h1a, 8'hff, 8'h5a);
    $display("test low range done");
    report_and_stop;
  end
endmodule
`default_nettype wire
